// *** bench/aifc_adc_model.sv ***
// converter stand-in: answers each start pulse after a set delay
`timescale 1ns/1ps
module aifc_adc_model (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        convert,
	input  wire logic [7:0]  lat,
	input  wire logic [11:0] code,
	output logic             adc_done,
	output logic [11:0]      adc_data
);
	logic       run_q;
	logic [7:0] cnt_q;
	// inverted outside the done cycle so stale data never looks valid
	assign adc_data = adc_done ? code : ~code;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			run_q <= 1'h0;
			cnt_q <= 8'h00;
			adc_done <= 1'h0;
		end else begin
			adc_done <= run_q && cnt_q == 8'h00;
			if (convert) begin
				run_q <= 1'h1;
				cnt_q <= lat;
			end else if (run_q) begin
				run_q <= cnt_q != 8'h00;
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule

// *** bench/analog_input_fifo_control_test.sv ***
// self-checking bench for the analog input control block
`timescale 1ns/1ps
module analog_input_fifo_control_test;
	logic        ref_clk, reset, reg_wr, reg_rd, external_convert_n, adc_done, adc_convert_q;
	logic        dma_enable_q, ai_int_req_q, frequency_output_q, frequency_output_oe_q;
	logic [4:0]  reg_addr, counter_out_q, counter_oe_q;
	logic [15:0] reg_wdata, reg_rdata_q, dac0_q, dac1_q, rv;
	logic [11:0] adc_data, code;
	logic [7:0]  lat;
	logic [3:0]  channel_q;
	logic [1:0]  gain_q;
	int          error_cnt, compares, conv_cnt, n0, i;
	aifc_top u_dut (
		.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .external_convert_n(external_convert_n),
		.adc_done(adc_done), .adc_data(adc_data), .adc_convert_q(adc_convert_q),
		.reg_rdata_q(reg_rdata_q), .channel_q(channel_q), .gain_q(gain_q),
		.dma_enable_q(dma_enable_q), .ai_int_req_q(ai_int_req_q),
		.counter_out_q(counter_out_q), .counter_oe_q(counter_oe_q),
		.frequency_output_q(frequency_output_q),
		.frequency_output_oe_q(frequency_output_oe_q), .dac0_q(dac0_q), .dac1_q(dac1_q));
	aifc_adc_model u_adc (.ref_clk(ref_clk), .reset(reset), .convert(adc_convert_q),
		.lat(lat), .code(code), .adc_done(adc_done), .adc_data(adc_data));
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (adc_convert_q === 1'h1) conv_cnt++;
	end
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1;
		rv = reg_rdata_q;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] e);
		rd(a);
		chk(rv, e);
	endtask
	// waits out the converter delay plus push and status latency
	task automatic conv(input logic ext, input logic [11:0] c);
		code = c;
		if (ext) begin
			@(posedge ref_clk);
			external_convert_n <= 1'h0;
			repeat (2) @(posedge ref_clk);
			external_convert_n <= 1'h1;
		end else begin
			wr(aifc_pkg::OFS_START, 16'h0000);
		end
		repeat (lat + 8) @(posedge ref_clk);
	endtask
	initial begin
		repeat (40000) @(posedge ref_clk);
		error_cnt++;
		close_out();
	end
	initial begin
		reset = 1'h1;
		{reg_wr, reg_rd, reg_addr, reg_wdata, code} = '0;
		external_convert_n = 1'h1;
		lat = 8'h02;
		repeat (5) @(posedge ref_clk);
		reset <= 1'h0;
		wr(aifc_pkg::OFS_CMD2, 16'h0001);
		#1;
		chk(16'(dma_enable_q), 16'h0001);
		wr(aifc_pkg::OFS_CMD1, 16'h0000);
		wr(aifc_pkg::OFS_CMD2, 16'h0000);
		wr(aifc_pkg::OFS_MUXGAIN, 16'h0000);
		wr(aifc_pkg::OFS_CC_CMD, 16'hFFFF);
		wr(aifc_pkg::OFS_CC_CMD, 16'hFFEF);
		wr(aifc_pkg::OFS_CC_CMD, 16'hFF17);
		wr(aifc_pkg::OFS_CC_DATA, 16'hF000);
		for (i = 1; i < 6; i++) begin
			wr(aifc_pkg::OFS_CC_CMD, 16'hFF00 + i[15:0]);
			wr(aifc_pkg::OFS_CC_DATA, 16'h0004);
			wr(aifc_pkg::OFS_CC_CMD, 16'hFF08 + i[15:0]);
			wr(aifc_pkg::OFS_CC_DATA, 16'h0003);
		end
		wr(aifc_pkg::OFS_CC_CMD, 16'hFF5F);
		wr(aifc_pkg::OFS_CLEAR, 16'h0000);
		wr(aifc_pkg::OFS_SECOND_INTERRUPT_CLEAR, 16'h0000);
		wr(aifc_pkg::OFS_DAC0, 16'h0000);
		wr(aifc_pkg::OFS_DAC1, 16'h0000);
		@(posedge ref_clk);
		#1;
		chk({dma_enable_q, ai_int_req_q, gain_q, channel_q, counter_oe_q,
			frequency_output_oe_q, frequency_output_q, 1'h0}, 16'h0000);
		chk(dac0_q | dac1_q, 16'h0000);
		rdc(aifc_pkg::OFS_STATUS, 16'h0000);
		rdc(aifc_pkg::OFS_CC_CMD, 16'h0100);
		rdc(aifc_pkg::OFS_CC_DATA, 16'h0003);
		wr(aifc_pkg::OFS_CC_CMD, 16'hFF04);
		wr(aifc_pkg::OFS_CC_DATA, 16'h0000);
		@(posedge ref_clk);
		#1;
		chk({6'h00, counter_oe_q, counter_out_q}, 16'h0100);
		$display("test init done");
		wr(aifc_pkg::OFS_MUXGAIN, 16'h00C5);
		#1;
		chk({10'h000, gain_q, channel_q}, 16'h0035);
		wr(aifc_pkg::OFS_CMD1, 16'h0008);
		lat = 8'd200;
		n0 = conv_cnt;
		code = 12'hFFF;
		wr(aifc_pkg::OFS_START, 16'h0000);
		rv = '0;
		for (i = 0; i < 500 && rv[13] !== 1'h1; i++) rd(aifc_pkg::OFS_STATUS);
		chk(rv, 16'h2000);
		rdc(aifc_pkg::OFS_FIFO, 16'h0FFF);
		rdc(aifc_pkg::OFS_STATUS, 16'h0000);
		chk(16'(conv_cnt - n0), 16'h0001);
		chk({10'h000, gain_q, channel_q}, 16'h0035);
		$display("test single done");
		wr(aifc_pkg::OFS_CMD1, 16'h0000);
		lat = 8'h01;
		conv(1'h1, 12'h000);
		conv(1'h0, 12'hFFF);
		rdc(aifc_pkg::OFS_FIFO, 16'hF800);
		rdc(aifc_pkg::OFS_FIFO, 16'h07FF);
		$display("test coding done");
		wr(aifc_pkg::OFS_CMD1, 16'h0088);
		lat = 8'h00;
		for (i = 0; i < 513; i++) conv(1'h0, i[11:0]);
		rdc(aifc_pkg::OFS_STATUS, 16'h2200);
		for (i = 0; i < 512; i++) rdc(aifc_pkg::OFS_FIFO, i[15:0]);
		rdc(aifc_pkg::OFS_STATUS, 16'h0200);
		$display("test overflow done");
		conv(1'h0, 12'h123);
		chk(16'(ai_int_req_q), 16'h0001);
		wr(aifc_pkg::OFS_CLEAR, 16'h0000);
		rdc(aifc_pkg::OFS_STATUS, 16'h0000);
		chk(16'(ai_int_req_q), 16'h0000);
		$display("test clear done");
		close_out();
	end
endmodule

// *** rtl/aifc_conv.sv ***
// single conversion sequencer facing the converter
`timescale 1ns/1ps
module aifc_conv (
	input  wire logic                    ref_clk,
	input  wire logic                    reset,
	input  wire logic                    start,
	input  wire logic                    adc_done,
	input  wire logic [aifc_pkg::CW-1:0] adc_data,
	output logic                         adc_convert_q,
	output logic                         push_q,
	output logic [aifc_pkg::CW-1:0]      push_data_q,
	output logic                         busy
);
	aifc_pkg::aifc_conv_e state_q;
	aifc_pkg::aifc_tmr_t  tmr_q;

	assign busy = (state_q == aifc_pkg::CV_WAIT);

	// a converter that never answers is given up after the time limit
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= aifc_pkg::CV_IDLE;
			tmr_q   <= '0;
		end else begin
			unique case (state_q)
				aifc_pkg::CV_IDLE: begin
					tmr_q <= '0;
					if (start) begin
						state_q <= aifc_pkg::CV_WAIT;
					end
				end
				aifc_pkg::CV_WAIT: begin
					tmr_q <= tmr_q + aifc_pkg::aifc_tmr_t'(1);
					if (adc_done || tmr_q == aifc_pkg::TMR_LAST) begin
						state_q <= aifc_pkg::CV_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			adc_convert_q <= 1'b0;
			push_q        <= 1'b0;
			push_data_q   <= '0;
		end else begin
			adc_convert_q <= start && !busy;
			push_q        <= busy && adc_done;
			if (busy && adc_done) begin
				push_data_q <= adc_data;
			end
		end
	end
endmodule

// *** rtl/aifc_mem.sv ***
// result memory, 512 words, registered read with write-first bypass
`timescale 1ns/1ps
module aifc_mem (
	input  wire logic ref_clk,
	input  wire logic reset,
	aifc_mem_if.mem   m
);
	logic [aifc_pkg::CW-1:0] ram [2**aifc_pkg::FAW];

	always_ff @(posedge ref_clk) begin
		if (m.wr_en) begin
			ram[m.wr_addr] <= m.wr_data;
		end
	end

	// bypass so a word pushed into an empty memory is visible at once
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			m.rd_data <= '0;
		end else if (m.wr_en && m.wr_addr == m.rd_addr) begin
			m.rd_data <= m.wr_data;
		end else begin
			m.rd_data <= ram[m.rd_addr];
		end
	end
endmodule

// *** rtl/aifc_top.sv ***
// analog input control: registers, result fifo, counter chip front
`timescale 1ns/1ps
// Behaviour
// - after init: dma and interrupts off, counters hiz, fifo empty, channel 0 gain 1
// - after counter init: 16-bit mode, frequency output off, outputs hiz, counts non-terminal
// - channel/gain register: bits 7..6 gain, bits 3..0 channel
// - channel/gain setting holds until next written
// - write to start register starts exactly one conversion
// - low pulse on external convert input starts one conversion
// - conversion result goes into fifo at end of conversion
// - result available bit set when fifo non-empty, within 10 us
// - each fifo read removes oldest result
// - more than 512 results unread sets overflow flag
// - clear register write clears overflow and empties fifo
// - coding bit set gives straight binary, clear gives two's complement
// - two's complement results sign-extended to 16 bits
// - clear register write cancels pending analog input interrupt request
module aifc_top (
	input  wire logic                      ref_clk,
	input  wire logic                      reset,
	input  wire logic [aifc_pkg::AW-1:0]   reg_addr,
	input  wire logic [aifc_pkg::DW-1:0]   reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire logic                      external_convert_n,
	input  wire logic                      adc_done,
	input  wire logic [aifc_pkg::CW-1:0]   adc_data,
	output logic                           adc_convert_q,
	output logic [aifc_pkg::DW-1:0]        reg_rdata_q,
	output logic [3:0]                     channel_q,
	output logic [1:0]                     gain_q,
	output logic                           dma_enable_q,
	output logic                           ai_int_req_q,
	output logic [aifc_pkg::CC_N-1:0]      counter_out_q,
	output logic [aifc_pkg::CC_N-1:0]      counter_oe_q,
	output logic                           frequency_output_q,
	output logic                           frequency_output_oe_q,
	output logic [aifc_pkg::DW-1:0]        dac0_q,
	output logic [aifc_pkg::DW-1:0]        dac1_q
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// zero-extended straight or sign-extended two's complement coding
	function automatic logic [aifc_pkg::DW-1:0] fmt(input logic [aifc_pkg::CW-1:0] c,
							input logic straight);
		logic [aifc_pkg::CW-1:0] t;
		t = c ^ aifc_pkg::TWOS_FLIP;
		if (straight) begin
			fmt = {{(aifc_pkg::DW - aifc_pkg::CW){1'b0}}, c};
		end else begin
			fmt = {{(aifc_pkg::DW - aifc_pkg::CW){t[aifc_pkg::CW-1]}}, t};
		end
	endfunction

	function automatic logic cc_hit(input logic [3:0] p, input int i);
		cc_hit = (p[2:0] == 3'(i + 1));
	endfunction

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic wr_cmd1, wr_cmd2, wr_mux, wr_start, clr, wr_cc_cmd, wr_cc_data;
	logic rd_fifo;
	logic [aifc_pkg::DW-1:0] cmd1_q;
	logic ext_prev_q, ext_fall, conv_start;
	logic conv_push, conv_busy;
	logic [aifc_pkg::CW-1:0] conv_data;

	assign wr_cmd1    = reg_wr && reg_addr == aifc_pkg::OFS_CMD1;
	assign wr_cmd2    = reg_wr && reg_addr == aifc_pkg::OFS_CMD2;
	assign wr_mux     = reg_wr && reg_addr == aifc_pkg::OFS_MUXGAIN;
	assign wr_start   = reg_wr && reg_addr == aifc_pkg::OFS_START;
	assign clr        = reg_wr && reg_addr == aifc_pkg::OFS_CLEAR;
	assign wr_cc_cmd  = reg_wr && reg_addr == aifc_pkg::OFS_CC_CMD
			    && reg_wdata[15:8] == aifc_pkg::CC_PREFIX;
	assign wr_cc_data = reg_wr && reg_addr == aifc_pkg::OFS_CC_DATA;
	assign rd_fifo    = reg_rd && reg_addr == aifc_pkg::OFS_FIFO;

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	// init defaults
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cmd1_q       <= '0;
			dma_enable_q <= 1'b0;
		end else begin
			if (wr_cmd1) begin
				cmd1_q <= reg_wdata;
			end
			if (wr_cmd2) begin
				dma_enable_q <= reg_wdata[aifc_pkg::BIT_DMA_EN];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			channel_q <= '0;
			gain_q    <= '0;
		end else if (wr_mux) begin
			channel_q <= reg_wdata[aifc_pkg::CHAN_HI:aifc_pkg::CHAN_LO];
			gain_q    <= reg_wdata[aifc_pkg::GAIN_HI:aifc_pkg::GAIN_LO];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dac0_q <= '0;
			dac1_q <= '0;
		end else begin
			if (reg_wr && reg_addr == aifc_pkg::OFS_DAC0) begin
				dac0_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == aifc_pkg::OFS_DAC1) begin
				dac1_q <= reg_wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// conversion start
	// ------------------------------------------------------------
	// falling edge of external convert
	assign ext_fall = ext_prev_q && !external_convert_n;
	assign conv_start = wr_start || ext_fall;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ext_prev_q <= 1'b1;
		end else begin
			ext_prev_q <= external_convert_n;
		end
	end

	aifc_conv u_conv (
		.ref_clk       (ref_clk),
		.reset         (reset),
		.start         (conv_start),
		.adc_done      (adc_done),
		.adc_data      (adc_data),
		.adc_convert_q (adc_convert_q),
		.push_q        (conv_push),
		.push_data_q   (conv_data),
		.busy          (conv_busy)
	);

	// ------------------------------------------------------------
	// result fifo
	// ------------------------------------------------------------
	aifc_mem_if mif ();
	aifc_pkg::aifc_ptr_t wr_ptr_q, rd_ptr_q, rd_ptr_d;
	aifc_pkg::aifc_cnt_t cnt_q, cnt_d;
	logic full, push_ok, pop, avail_q, ovf_q;

	aifc_mem u_mem (
		.ref_clk (ref_clk),
		.reset   (reset),
		.m       (mif.mem)
	);

	assign full = (cnt_q == aifc_pkg::FIFO_FULL);
	// no push into a full fifo unless a clear empties it in the same cycle
	assign push_ok = conv_push && (!full || clr);
	assign pop = rd_fifo && cnt_q != '0;

	always_comb begin
		if (clr) begin
			cnt_d    = aifc_pkg::aifc_cnt_t'(push_ok);
			rd_ptr_d = '0;
		end else begin
			cnt_d    = cnt_q + aifc_pkg::aifc_cnt_t'(push_ok) - aifc_pkg::aifc_cnt_t'(pop);
			rd_ptr_d = rd_ptr_q + aifc_pkg::aifc_ptr_t'(pop);
		end
	end

	// read address runs one ahead so back-to-back reads see fresh data
	assign mif.wr_en   = push_ok;
	assign mif.wr_addr = clr ? '0 : wr_ptr_q;
	assign mif.wr_data = conv_data;
	assign mif.rd_addr = rd_ptr_d;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else begin
			wr_ptr_q <= mif.wr_addr + aifc_pkg::aifc_ptr_t'(push_ok);
			rd_ptr_q <= rd_ptr_d;
			cnt_q    <= cnt_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			avail_q <= 1'b0;
		end else begin
			avail_q <= cnt_d != '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ovf_q <= 1'b0;
		end else if (conv_push && full && !clr) begin
			ovf_q <= 1'b1;
		end else if (clr) begin
			ovf_q <= 1'b0;
		end
	end

	// clear cancels request, new result wins
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ai_int_req_q <= 1'b0;
		end else if (push_ok && cmd1_q[aifc_pkg::BIT_IRQ_EN]) begin
			ai_int_req_q <= 1'b1;
		end else if (clr || !cmd1_q[aifc_pkg::BIT_IRQ_EN]) begin
			ai_int_req_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// counter chip front
	// ------------------------------------------------------------
	logic                    cc16_q;
	logic [aifc_pkg::DW-1:0] cc_mm_q;
	logic [3:0]              cc_ptr_q;
	logic [aifc_pkg::DW-1:0] cc_mode_q [aifc_pkg::CC_N];
	logic [aifc_pkg::DW-1:0] cc_load_q [aifc_pkg::CC_N];
	logic [aifc_pkg::DW-1:0] cc_cnt_q  [aifc_pkg::CC_N];
	logic [7:0]              cb;

	assign cb = reg_wdata[7:0];

	// master reset, mode, pointer, load commands
	always_ff @(posedge ref_clk) begin
		if (reset || (wr_cc_cmd && cb == aifc_pkg::CC_MRESET)) begin
			cc16_q   <= 1'b0;
			cc_mm_q  <= '0;
			cc_ptr_q <= '0;
			for (int i = 0; i < aifc_pkg::CC_N; i++) begin
				cc_mode_q[i] <= aifc_pkg::CC_MODE_RST;
				cc_load_q[i] <= '0;
				cc_cnt_q[i]  <= '0;
			end
		end else if (wr_cc_cmd) begin
			if (cb == aifc_pkg::CC_MODE16) begin
				cc16_q <= 1'b1;
			end else if (cb == aifc_pkg::CC_PTR_MM) begin
				cc_ptr_q <= aifc_pkg::CC_PTR_MASTER;
			end else if (cb[7:4] == aifc_pkg::CC_SEL_GRP) begin
				cc_ptr_q <= cb[3:0];
			end else if (cb[7:5] == aifc_pkg::CC_LOAD_GRP) begin
				for (int i = 0; i < aifc_pkg::CC_N; i++) begin
					if (cb[i]) begin
						cc_cnt_q[i] <= cc_load_q[i];
					end
				end
			end
		end else if (wr_cc_data) begin
			if (cc_ptr_q == aifc_pkg::CC_PTR_MASTER) begin
				cc_mm_q <= reg_wdata;
			end
			for (int i = 0; i < aifc_pkg::CC_N; i++) begin
				if (cc_hit(cc_ptr_q, i) && cc_ptr_q[3]) begin
					cc_load_q[i] <= reg_wdata;
				end else if (cc_hit(cc_ptr_q, i)) begin
					cc_mode_q[i] <= reg_wdata;
				end
			end
		end
	end

	// outputs hiz unless mode drives them
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			counter_oe_q  <= '0;
			counter_out_q <= '0;
		end else begin
			for (int i = 0; i < aifc_pkg::CC_N; i++) begin
				counter_oe_q[i]  <= cc_mode_q[i][2:0] != aifc_pkg::OUT_HIZ;
				counter_out_q[i] <= cc_mode_q[i][2:0] != aifc_pkg::OUT_LOW
						    && cc_cnt_q[i] == '0;
			end
		end
	end

	// frequency output simplified to half the board clock when on
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			frequency_output_oe_q <= 1'b0;
			frequency_output_q    <= 1'b0;
		end else begin
			frequency_output_oe_q <= !cc_mm_q[aifc_pkg::MM_FREQUENCY_OUTPUT_OFF];
			frequency_output_q    <= !cc_mm_q[aifc_pkg::MM_FREQUENCY_OUTPUT_OFF] && !frequency_output_q;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	logic [aifc_pkg::DW-1:0] status_w, cc_status_w, cc_rd_w;

	always_comb begin
		status_w = '0;
		status_w[aifc_pkg::BIT_AVAIL] = avail_q;
		status_w[aifc_pkg::BIT_OVF]   = ovf_q;
		status_w[aifc_pkg::BIT_BUSY]  = conv_busy;
		cc_status_w = '0;
		cc_status_w[aifc_pkg::CC_N-1:0]  = counter_out_q;
		cc_status_w[aifc_pkg::BIT_CC16]  = cc16_q;
		cc_rd_w = (cc_ptr_q == aifc_pkg::CC_PTR_MASTER) ? cc_mm_q : '0;
		for (int i = 0; i < aifc_pkg::CC_N; i++) begin
			if (cc_hit(cc_ptr_q, i)) begin
				cc_rd_w = cc_ptr_q[3] ? cc_load_q[i] : cc_mode_q[i];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !reg_rd) begin
			reg_rdata_q <= '0;
		end else begin
			unique case (reg_addr)
				aifc_pkg::OFS_STATUS:  reg_rdata_q <= status_w;
				aifc_pkg::OFS_FIFO:    reg_rdata_q <= fmt(mif.rd_data,
									 cmd1_q[aifc_pkg::BIT_BINCODE]);
				aifc_pkg::OFS_CC_CMD:  reg_rdata_q <= cc_status_w;
				aifc_pkg::OFS_CC_DATA: reg_rdata_q <= cc_rd_w;
				default:               reg_rdata_q <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	localparam int A_CONV = aifc_pkg::CONV_CYC;
	default clocking cb_a @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_mux_bits;
		wr_mux |=> channel_q == $past(reg_wdata[3:0]) && gain_q == $past(reg_wdata[7:6]);
	endproperty
	a_mux_bits: assert property (p_mux_bits) else $error("channel/gain not taken");

	property p_mux_hold;
		!wr_mux |=> $stable(channel_q) && $stable(gain_q);
	endproperty
	a_mux_hold: assert property (p_mux_hold) else $error("channel/gain moved");

	property p_dma_off;
		wr_cmd2 && reg_wdata == '0 |=> !dma_enable_q [*3];
	endproperty
	a_dma_off: assert property (p_dma_off) else $error("dma not off");

	property p_sw_start;
		wr_start && !conv_busy |=> adc_convert_q && conv_busy ##1 !adc_convert_q;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("no single convert");

	property p_ext_start;
		$fell(external_convert_n) && !conv_busy |=> adc_convert_q;
	endproperty
	a_ext_start: assert property (p_ext_start) else $error("ext convert lost");

	property p_conv_bound;
		$rose(conv_busy) |-> ##[1:A_CONV] !conv_busy;
	endproperty
	a_conv_bound: assert property (p_conv_bound) else $error("conversion too long");

	property p_push;
		conv_push && !full && !clr && !pop |=> cnt_q == $past(cnt_q) + 1 && avail_q;
	endproperty
	a_push: assert property (p_push) else $error("result not stored");

	property p_pop;
		pop && !conv_push |=> cnt_q == $past(cnt_q) - 1;
	endproperty
	a_pop: assert property (p_pop) else $error("read did not remove");

	property p_last;
		pop && cnt_q == 1 && !conv_push |=> !avail_q;
	endproperty
	a_last: assert property (p_last) else $error("available stuck");

	property p_ovf;
		conv_push && full && !clr |=> ovf_q
			&& cnt_q == aifc_pkg::FIFO_FULL - aifc_pkg::aifc_cnt_t'($past(pop));
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow mishandled");

	property p_clear;
		clr && !conv_push |=> cnt_q == '0 && !ovf_q && !avail_q;
	endproperty
	a_clear: assert property (p_clear) else $error("clear incomplete");

	property p_irq_clr;
		clr && !push_ok |=> !ai_int_req_q;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("request not cancelled");

	property p_twos;
		rd_fifo && !cmd1_q[aifc_pkg::BIT_BINCODE] |=> reg_rdata_q[15:11] == '0
			|| reg_rdata_q[15:11] == '1;
	endproperty
	a_twos: assert property (p_twos) else $error("not sign-extended");

	property p_straight;
		rd_fifo && cmd1_q[aifc_pkg::BIT_BINCODE] |=> reg_rdata_q[15:12] == '0;
	endproperty
	a_straight: assert property (p_straight) else $error("binary out of range");

	property p_cc16;
		wr_cc_cmd && cb == aifc_pkg::CC_MODE16 |=> cc16_q;
	endproperty
	a_cc16: assert property (p_cc16) else $error("16-bit mode not set");
endmodule

// *** shared/aifc_mem_if.sv ***
// result memory port bundle
`timescale 1ns/1ps
interface aifc_mem_if;
	logic                          wr_en;
	logic [aifc_pkg::FAW-1:0]      wr_addr;
	logic [aifc_pkg::CW-1:0]       wr_data;
	logic [aifc_pkg::FAW-1:0]      rd_addr;
	logic [aifc_pkg::CW-1:0]       rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// *** shared/aifc_pkg.sv ***
// constants and types shared by the analog input control block
package aifc_pkg;
	localparam int AW  = 5;
	localparam int DW  = 16;
	localparam int CW  = 12;
	localparam int FAW = 9;
	localparam int CC_N = 5;
	typedef logic [FAW-1:0] aifc_ptr_t;
	typedef logic [FAW:0]   aifc_cnt_t;
	typedef logic [9:0]     aifc_tmr_t;
	localparam aifc_cnt_t FIFO_FULL = 10'h200;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [AW-1:0] OFS_CMD1    = 5'h00;
	localparam logic [AW-1:0] OFS_CMD2    = 5'h02;
	localparam logic [AW-1:0] OFS_STATUS  = 5'h04;
	localparam logic [AW-1:0] OFS_MUXGAIN = 5'h06;
	localparam logic [AW-1:0] OFS_FIFO    = 5'h08;
	localparam logic [AW-1:0] OFS_START   = 5'h0A;
	localparam logic [AW-1:0] OFS_CLEAR   = 5'h0C;
	localparam logic [AW-1:0] OFS_SECOND_INTERRUPT_CLEAR = 5'h0E;
	localparam logic [AW-1:0] OFS_CC_CMD  = 5'h10;
	localparam logic [AW-1:0] OFS_CC_DATA = 5'h12;
	localparam logic [AW-1:0] OFS_DAC0    = 5'h14;
	localparam logic [AW-1:0] OFS_DAC1    = 5'h16;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_BINCODE = 3;
	localparam int BIT_IRQ_EN  = 7;
	localparam int BIT_DMA_EN  = 0;
	localparam int BIT_AVAIL   = 13;
	localparam int BIT_OVF     = 9;
	localparam int BIT_BUSY    = 7;
	localparam int BIT_CC16    = 8;
	localparam int GAIN_HI = 7;
	localparam int GAIN_LO = 6;
	localparam int CHAN_HI = 3;
	localparam int CHAN_LO = 0;
	localparam int MM_FREQUENCY_OUTPUT_OFF = 12;
	localparam logic [CW-1:0] TWOS_FLIP = 12'h800;
	// ------------------------------------------------------------
	// counter chip commands
	// ------------------------------------------------------------
	localparam logic [7:0] CC_PREFIX   = 8'hFF;
	localparam logic [7:0] CC_MRESET   = 8'hFF;
	localparam logic [7:0] CC_MODE16   = 8'hEF;
	localparam logic [7:0] CC_PTR_MM   = 8'h17;
	localparam logic [3:0] CC_SEL_GRP  = 4'h0;
	localparam logic [2:0] CC_LOAD_GRP = 3'h2;
	localparam logic [3:0] CC_PTR_MASTER = 4'h7;
	localparam logic [2:0] OUT_LOW = 3'h0;
	localparam logic [2:0] OUT_HIZ = 3'h4;
	localparam logic [DW-1:0] CC_MODE_RST = 16'h0004;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CONV_LIMIT_NS = 10000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_CYC = CONV_LIMIT_NS / CLK_PERIOD_NS;
	localparam aifc_tmr_t TMR_LAST = aifc_tmr_t'(CONV_CYC - 1);
	typedef enum logic {CV_IDLE, CV_WAIT} aifc_conv_e;
endpackage
